// [core/sso_status_outputs.sv]
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Rotation detect closes when speed is at or above the detection level.
// - Rotation detect opens when speed is below the detection level.
// - Level accepts 1 to 10000 rpm, defaults to 20, applies immediately.
// - Drive ready closes only when power-enable command can be accepted.
// - Drive ready needs main power on and no alarm; either loss drops it.
// - With absolute encoder, data request input must also be on.
// - With absolute encoder, position data must finish sending before ready.
// - Rotation detect goes to the terminal chosen by its assignment setting.
// - Drive ready goes to the terminal chosen by its own assignment setting.
module sso_status_outputs (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	input  wire logic [sso_pkg::SPEED_W-1:0]   motor_speed,
	input  wire logic                          level_write,
	input  wire logic [15:0]                   level_wdata,
	input  wire logic                          main_power_on,
	input  wire logic                          alarm_active,
	input  wire logic                          abs_encoder,
	input  wire logic                          abs_data_request_in,
	input  wire logic                          abs_send_done,
	input  wire sso_pkg::sso_assign_t          assign_cfg,
	output logic                               abs_send_start,
	output logic [15:0]                        rotation_level_setting,
	output logic                               rotation_detect_out,
	output logic                               drive_ready_out,
	output logic [sso_pkg::TERM_N-1:0]         terminal_out
);
	import sso_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for the contacts coming from outside.
	// All four contacts travel together as one struct so that they see the
	// same two-stage delay. They are independent levels, so a skew of one cycle
	// between them only delays ready by a cycle and is harmless.
	// Reset clears the synchronisers to the open state, so ready cannot
	// glitch high while the block leaves reset.

	sso_status_t sync1_q;
	sso_status_t sync2_q;
	sso_status_t sync1_d;

	always_comb begin
		sync1_d.main_power_on       = main_power_on;
		sync1_d.alarm_active        = alarm_active;
		sync1_d.abs_encoder         = abs_encoder;
		sync1_d.abs_data_request_in = abs_data_request_in;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync1_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Rotation detection level setting.
	// A valid write is visible on the next edge and is used by the comparator
	// straight away; no restart of the block is needed.

	function automatic logic level_ok(input logic [15:0] v);
		return (v >= LEVEL_MIN) && (v <= LEVEL_MAX);
	endfunction

	logic [15:0] level_d;
	logic [15:0] level_q;

	// Out-of-range writes are dropped so the comparator never sees level zero.
	always_comb begin
		level_d = level_q;
		if (level_write && level_ok(level_wdata)) begin
			level_d = level_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= LEVEL_RESET;
		end else begin
			level_q <= level_d;
		end
	end

	assign rotation_level_setting = level_q;

	//////////////////////////////////////////////////////////////////////////
	// Absolute data transfer sequencing.

	// The sender is started with a single-cycle pulse and reports completion on
	// abs_send_done. Completion is only honoured while a transfer is running,
	// so a stale done from an earlier transfer cannot mark the data as sent.
	// Ready stays low from the start pulse until the state reaches done, and
	// a host that drops the request must wait for a fresh transfer.
	sso_abs_state_t abs_state_d;
	sso_abs_state_t abs_state_q;
	logic           start_d;
	logic           start_q;

	always_comb begin
		abs_state_d = abs_state_q;
		start_d     = 1'b0;
		if (!sync2_q.abs_encoder || !sync2_q.abs_data_request_in) begin
			// Dropping the request restarts the transfer on the next request.
			abs_state_d = ABS_IDLE;
		end else begin
			unique case (abs_state_q)
				ABS_IDLE: begin
					abs_state_d = ABS_SENDING;
					start_d     = 1'b1;
				end
				ABS_SENDING: begin
					if (abs_send_done) begin
						abs_state_d = ABS_DONE;
					end
				end
				ABS_DONE: begin
					abs_state_d = ABS_DONE;
				end
				default: begin
					// The fourth code of the encoding is unused; recover through idle.
					abs_state_d = ABS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			abs_state_q <= ABS_IDLE;
			start_q     <= 1'b0;
		end else begin
			abs_state_q <= abs_state_d;
			start_q     <= start_d;
		end
	end

	assign abs_send_start = start_q;

	//////////////////////////////////////////////////////////////////////////
	// Output conditions, recomputed every cycle.
	//
	// Neither output latches: each flop takes a fresh value on every edge, so
	// a condition that goes away is seen on the contact one cycle later.
	// Both contacts are registered so that they never glitch between edges.
	// Speed is compared without synchronisers because it comes from logic on
	// this clock; the contact inputs arrive two cycles late through the
	// synchronisers, which puts drive ready three cycles behind its pins.

	function automatic logic speed_reached(input logic [SPEED_W-1:0] speed, input logic [15:0] level);
		return speed >= level;
	endfunction

	logic rot_d;
	logic rot_q;

	// The level is read from its register, so a write changes the comparison
	// on the edge that takes it and the contact one edge after that.
	always_comb begin
		rot_d = speed_reached(motor_speed, level_q);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rot_q <= 1'b0;
		end else begin
			rot_q <= rot_d;
		end
	end

	assign rotation_detect_out = rot_q;

	logic power_ok;
	logic abs_ok;
	logic rdy_d;
	logic rdy_q;

	// Without an absolute encoder the request input and the transfer state are
	// ignored, so an incremental setup is ready as soon as power is good.
	// Loss of power or an alarm clears ready on the next edge of the
	// synchronised inputs; nothing holds it up once a condition is gone.
	always_comb begin
		power_ok = sync2_q.main_power_on && !sync2_q.alarm_active;
		abs_ok   = 1'b1;
		if (sync2_q.abs_encoder) begin
			abs_ok = sync2_q.abs_data_request_in && (abs_state_q == ABS_DONE);
		end
		rdy_d    = power_ok && abs_ok;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= rdy_d;
		end
	end

	assign drive_ready_out = rdy_q;

	//////////////////////////////////////////////////////////////////////////
	// Terminal routing.
	// Routing adds one register stage, so a terminal follows its output one
	// cycle later. Terminal zero means unassigned and is never driven.
	// If both outputs pick one terminal, the contact closes when either is active.

	sso_terminal_map u_map (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.rotation_active (rot_q),
		.ready_active    (rdy_q),
		.assign_cfg      (assign_cfg),
		.terminal_out    (terminal_out)
	);
endmodule

// [core/sso_terminal_map.sv]
`timescale 1ns/1ps
module sso_terminal_map (
	input  wire logic                          mclk,
	input  wire logic                          rst_n,
	input  wire logic                          rotation_active,
	input  wire logic                          ready_active,
	input  wire sso_pkg::sso_assign_t          assign_cfg,
	output logic [sso_pkg::TERM_N-1:0]         terminal_out
);
	import sso_pkg::*;

	logic [TERM_N-1:0] term_d;
	logic [TERM_N-1:0] term_q;

	// Terminal 0 means unassigned; if both land on one terminal they are ORed.
	always_comb begin
		term_d = '0;
		if (assign_cfg.rotation_out_assign != TERM_NONE) begin
			term_d[assign_cfg.rotation_out_assign] = rotation_active;
		end
		if (assign_cfg.ready_out_assign != TERM_NONE) begin
			term_d[assign_cfg.ready_out_assign] = term_d[assign_cfg.ready_out_assign] | ready_active;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			term_q <= '0;
		end else begin
			term_q <= term_d;
		end
	end

	assign terminal_out = term_q;
endmodule

// [pkg/sso_pkg.sv]
package sso_pkg;

	// Speed figures are in units of one revolution per minute.
	localparam int            SPEED_W         = 16;
	localparam logic [15:0]   LEVEL_MIN       = 16'h0001;
	localparam logic [15:0]   LEVEL_MAX       = 16'h2710;
	localparam logic [15:0]   LEVEL_RESET     = 16'h0014;

	// Output terminal selection.
	localparam int            TERM_W          = 2;
	localparam int            TERM_N          = 4;
	localparam logic [1:0]    TERM_NONE       = 2'h0;
	localparam logic [1:0]    ROT_TERM_RESET  = 2'h2;
	localparam logic [1:0]    RDY_TERM_RESET  = 2'h3;

	typedef struct packed {
		logic main_power_on;
		logic alarm_active;
		logic abs_encoder;
		logic abs_data_request_in;
	} sso_status_t;

	typedef struct packed {
		logic [1:0] rotation_out_assign;
		logic [1:0] ready_out_assign;
	} sso_assign_t;

	typedef enum logic [1:0] {
		ABS_IDLE,
		ABS_SENDING,
		ABS_DONE
	} sso_abs_state_t;

endpackage

// [tb/sso_checker.sv]
`timescale 1ns/1ps
module sso_checker
	import sso_pkg::*;
(
	input logic                  mclk,
	input logic                  rst_n,
	input logic [SPEED_W-1:0]    motor_speed,
	input logic                  level_write,
	input logic [15:0]           level_wdata,
	input logic                  main_power_on,
	input logic                  alarm_active,
	input logic                  abs_encoder,
	input logic                  abs_data_request_in,
	input sso_assign_t           assign_cfg,
	input logic                  abs_send_start,
	input logic [15:0]           rotation_level_setting,
	input logic                  rotation_detect_out,
	input logic                  drive_ready_out,
	input logic [TERM_N-1:0]     terminal_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_rot_on: assert property ($past(rst_n) && $past(motor_speed) >= $past(rotation_level_setting) |-> rotation_detect_out)
		else $error("rotation low");
	a_rot_off: assert property ($past(rst_n) && $past(motor_speed) < $past(rotation_level_setting) |-> !rotation_detect_out)
		else $error("rotation high");
	a_level_take: assert property (level_write && level_wdata >= LEVEL_MIN && level_wdata <= LEVEL_MAX |=>
		rotation_level_setting == $past(level_wdata)) else $error("level lost");
	a_rdy_power: assert property (drive_ready_out |-> $past(main_power_on, 3) && !$past(alarm_active, 3))
		else $error("ready without power");
	a_rdy_request: assert property (drive_ready_out && $past(abs_encoder, 3) |-> $past(abs_data_request_in, 3))
		else $error("ready without request");
	a_start_unready: assert property (abs_send_start |-> !drive_ready_out) else $error("ready while sending");
	a_term_rot: assert property ($past(rst_n) && $past(rotation_detect_out) && $past(assign_cfg.rotation_out_assign) != 2'h0
		|-> terminal_out[$past(assign_cfg.rotation_out_assign)]) else $error("rotation terminal");
	a_term_rdy: assert property ($past(rst_n) && $past(drive_ready_out) && $past(assign_cfg.ready_out_assign) != 2'h0
		|-> terminal_out[$past(assign_cfg.ready_out_assign)]) else $error("ready terminal");
endmodule
bind sso_status_outputs sso_checker chk(.*);

// [tb/sso_host_model.sv]
`timescale 1ns/1ps
module sso_host_model (
	input  logic       mclk,
	input  logic       rst_n,
	input  logic       abs_send_start,
	input  logic [3:0] lat,
	output logic       abs_send_done
);
	logic [4:0] cnt_q;
	// The sender answers lat+1 cycles after the start pulse, so slow transfers are covered too.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) cnt_q <= 5'h0;
		else if (abs_send_start) cnt_q <= {1'b0, lat} + 5'h1;
		else if (cnt_q != 5'h0) cnt_q <= cnt_q - 5'h1;
	end
	assign abs_send_done = (cnt_q == 5'h1);
endmodule

// [tb/sso_status_outputs_test.sv]
`timescale 1ns/1ps
`define CHK(x, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", x, e, a); end end
module sso_status_outputs_test;
	import sso_pkg::*;
	logic mclk = 0, rst_n = 0, level_write = 0, main_power_on = 0, alarm_active = 0;
	logic abs_encoder = 0, abs_data_request_in = 0, abs_send_done, abs_send_start;
	logic rotation_detect_out, drive_ready_out;
	logic [15:0] motor_speed = 16'h0, level_wdata = 16'h0, rotation_level_setting;
	logic [3:0] terminal_out, lat = 4'h5;
	sso_assign_t assign_cfg = 4'h7;
	int fail_count = 0, n_checks = 0;
	always #4 mclk = ~mclk;
	sso_status_outputs uut(.*);
	sso_host_model host(.*);
	task tk(int n); repeat (n) @(posedge mclk); #1; endtask
	task wr(logic [15:0] v); level_write = 1; level_wdata = v; tk(1); level_write = 0; tk(1); endtask
	task t_level;
		`CHK("lvl", LEVEL_RESET, rotation_level_setting)
		wr(16'h0000); `CHK("lvl", LEVEL_RESET, rotation_level_setting)
		wr(16'h2711); `CHK("lvl", LEVEL_RESET, rotation_level_setting)
		wr(LEVEL_MAX); `CHK("lvl", LEVEL_MAX, rotation_level_setting)
		wr(16'h0064); `CHK("lvl", 16'h0064, rotation_level_setting)
	endtask
	task t_rot;
		motor_speed = 16'h0063; tk(2); `CHK("rot", 1'b0, rotation_detect_out)
		motor_speed = 16'h0064; tk(2); `CHK("rot", 1'b1, rotation_detect_out)
		`CHK("term1", 1'b1, terminal_out[1])
		motor_speed = 16'h0063; tk(2); `CHK("rot", 1'b0, rotation_detect_out)
		wr(16'h0063); `CHK("rot", 1'b1, rotation_detect_out)
	endtask
	task t_rdy;
		main_power_on = 1; tk(4); `CHK("rdy", 1'b1, drive_ready_out)
		`CHK("term3", 1'b1, terminal_out[3])
		alarm_active = 1; tk(4); `CHK("rdy", 1'b0, drive_ready_out)
		alarm_active = 0; tk(4); `CHK("rdy", 1'b1, drive_ready_out)
	endtask
	task t_abs;
		abs_encoder = 1; tk(4); `CHK("rdy", 1'b0, drive_ready_out)
		abs_data_request_in = 1; tk(3); `CHK("rdy", 1'b0, drive_ready_out)
		`CHK("start", 1'b1, abs_send_start)
		tk(12); `CHK("rdy", 1'b1, drive_ready_out)
		abs_data_request_in = 0; tk(4); `CHK("rdy", 1'b0, drive_ready_out)
	endtask
	task t_map;
		assign_cfg = 4'h8; tk(2); `CHK("term", 4'h4, terminal_out)
		assign_cfg = 4'h9; abs_encoder = 0; tk(5); `CHK("term", 4'h6, terminal_out)
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		end_sim;
	end
	initial begin
		tk(5);
		rst_n = 1;
		tk(1);
		t_level;
		t_rot;
		t_rdy;
		t_abs;
		t_map;
		end_sim;
	end
endmodule
